//--- hw/iae_pkg.sv
// constants, types and codes for the inadvertent energizing protection stage
// How it works
// - eight setting groups, one common selector
// - instant and time-delayed variants
// - start, trip, blocked outputs with on/off events
// - instant: start and trip share stamp
// - event stamps count whole milliseconds
// - resettable counter per output
// - mode codes 1..5, default on
// - force setting imposes status when enabled, in all modes except off
// - undervoltage limit 0.01 percent, default 50.00
// - activation delay before start, default 5 s
// - release delay before start clears, 0.25 s
// - trip when all currents exceed limit
// - trip also during running release delay
// - start output only when not blocked, unless forced
// - readable condition code 0..3
// - readable expected operating time
// - readable signed remaining activation time to start
// - readable voltage to setting ratio
// - readable minimum current to setting ratio
// - readable effective mode, same codes
// - blocked pick-up drives blocked output only
package iae_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned STAMP_MS = 1;
  localparam int unsigned MS_CYCLES = CLK_HZ / 1000 * STAMP_MS;
  localparam int unsigned STEP_MS = 5;
  localparam int unsigned ACT_DELAY_MS = 5000;
  localparam int unsigned REL_DELAY_MS = 250;

  // ----------------------------------------
  // settings widths and reset values
  // ----------------------------------------
  localparam int unsigned NUM_GROUPS = 8;
  localparam int unsigned DLY_W = 19;
  localparam logic [13:0] ULIM_RST = 14'h1388;
  localparam logic [DLY_W-1:0] ACT_RST = DLY_W'(ACT_DELAY_MS / STEP_MS);
  localparam logic [DLY_W-1:0] REL_RST = DLY_W'(REL_DELAY_MS / STEP_MS);
  localparam logic [5:0] ILIM_RST = 6'h01;
  localparam logic [16:0] RATIO_MAX = 17'h1e848;

  // ----------------------------------------
  // mode, force and condition codes
  // ----------------------------------------
  localparam logic [2:0] MODE_ON = 3'h1;
  localparam logic [2:0] MODE_BLOCKED = 3'h2;
  localparam logic [2:0] MODE_TEST = 3'h3;
  localparam logic [2:0] MODE_TEST_BLOCKED = 3'h4;
  localparam logic [2:0] MODE_OFF = 3'h5;
  localparam logic [1:0] COND_NORMAL = 2'h0;
  localparam logic [1:0] COND_START = 2'h1;
  localparam logic [1:0] COND_TRIP = 2'h2;
  localparam logic [1:0] COND_BLOCKED = 2'h3;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] REG_MODE = 8'h00;
  localparam logic [7:0] REG_FORCE = 8'h04;
  localparam logic [7:0] REG_CNT_CLR = 8'h08;
  localparam logic [7:0] REG_VARIANT = 8'h0c;
  localparam logic [7:0] REG_COND = 8'h10;
  localparam logic [7:0] REG_BEHAV = 8'h14;
  localparam logic [7:0] REG_EXP_TIME = 8'h18;
  localparam logic [7:0] REG_REMAIN = 8'h1c;
  localparam logic [7:0] REG_V_RATIO = 8'h20;
  localparam logic [7:0] REG_I_RATIO = 8'h24;
  localparam logic [7:0] REG_CNT_START = 8'h28;
  localparam logic [7:0] REG_CNT_TRIP = 8'h2c;
  localparam logic [7:0] REG_CNT_BLK = 8'h30;
  localparam logic [7:0] REG_GROUP_BASE = 8'h80;
  localparam int unsigned FORCE_EN_BIT = 4;

  // ----------------------------------------
  // carriers and pick-up states
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] phase_a_current_rms;
    logic [15:0] phase_b_current_rms;
    logic [15:0] phase_c_current_rms;
    logic [15:0] pos_seq_voltage;
  } meas_t;

  typedef struct packed {
    logic [2:0] changed;
    logic [2:0] level;
    logic [31:0] stamp;
  } event_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ARMING = 4'b0010,
    ST_STARTED = 4'b0100,
    ST_RELEASING = 4'b1000
  } pick_state_t;

endpackage

//--- hw/inadvertent_energizing_protection.sv
// inadvertent energizing protection stage with register port and event output
`timescale 1ns/100ps
`default_nettype none

module inadvertent_energizing_protection #(
  parameter int unsigned MS_TICK = iae_pkg::MS_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_meas_valid,
  input wire iae_pkg::meas_t i_meas,
  input wire logic i_block,
  input wire logic [2:0] i_group_sel,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_start,
  output logic o_trip,
  output logic o_blocked,
  output iae_pkg::event_t o_event
);
  import iae_pkg::*;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [13:0] ulim_q [NUM_GROUPS];
  logic [DLY_W-1:0] act_q [NUM_GROUPS];
  logic [5:0] ilim_q [NUM_GROUPS];
  logic [DLY_W-1:0] rel_q [NUM_GROUPS];
  logic [2:0] mode_q;
  logic force_en_q;
  logic [1:0] force_code_q;
  logic instant_q;
  logic [2:0] clr_d;
  pick_state_t st_q, st_d;
  logic [DLY_W-1:0] cnt_q, cnt_d;
  logic start_q, trip_q, blocked_q;
  logic start_d, trip_d, blocked_d;
  logic [31:0] ts_q;
  logic [17:0] div_q;
  logic ms_tick;
  logic [15:0] cnt_start_q, cnt_trip_q, cnt_blk_q;
  logic [16:0] v_ratio_q, i_ratio_q;
  logic [13:0] ulim;
  logic [DLY_W-1:0] act_del, rel_del;
  logic [5:0] ilim;
  logic uv, ovc, blk, active, pickup;
  logic [15:0] min_i;
  logic [19:0] remain;
  logic [2:0] grp;
  logic [1:0] fld;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic above_limit(input logic [15:0] cur, input logic [5:0] lim);
    above_limit = {2'h0, cur} > ({12'h0, lim} * 18'h5);
  endfunction

  function automatic logic [16:0] ratio(input logic [31:0] num, input logic [15:0] den);
    logic [31:0] q;
    q = 32'h0;
    if (den == 16'h0) begin
      ratio = RATIO_MAX;
    end else begin
      q = num / {16'h0, den};
      ratio = (q > {15'h0, RATIO_MAX}) ? RATIO_MAX : q[16:0];
    end
  endfunction

  // ----------------------------------------
  // active setting group and comparisons
  // ----------------------------------------
  assign ulim = ulim_q[i_group_sel];
  assign act_del = instant_q ? '0 : act_q[i_group_sel];
  assign ilim = ilim_q[i_group_sel];
  assign rel_del = rel_q[i_group_sel];
  assign uv = {2'h0, ulim} > i_meas.pos_seq_voltage;
  assign ovc = above_limit(i_meas.phase_a_current_rms, ilim) &&
               above_limit(i_meas.phase_b_current_rms, ilim) &&
               above_limit(i_meas.phase_c_current_rms, ilim);
  assign blk = i_block || mode_q == MODE_BLOCKED || mode_q == MODE_TEST_BLOCKED;
  assign active = mode_q != MODE_OFF;
  assign pickup = st_d == ST_STARTED || st_d == ST_RELEASING;

  always_comb begin
    min_i = i_meas.phase_a_current_rms;
    if (i_meas.phase_b_current_rms < min_i) begin
      min_i = i_meas.phase_b_current_rms;
    end
    if (i_meas.phase_c_current_rms < min_i) begin
      min_i = i_meas.phase_c_current_rms;
    end
  end

  // ----------------------------------------
  // pick-up state machine, one step per update
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    case (st_q)
      ST_IDLE: begin
        if (uv) begin
          cnt_d = DLY_W'(1);
          st_d = (act_del <= DLY_W'(1)) ? ST_STARTED : ST_ARMING;
        end
      end
      ST_ARMING: begin
        if (!uv) begin
          cnt_d = '0;
          st_d = ST_IDLE;
        end else begin
          cnt_d = cnt_q + DLY_W'(1);
          if (cnt_d >= act_del) begin
            st_d = ST_STARTED;
          end
        end
      end
      ST_STARTED: begin
        cnt_d = '0;
        if (!uv) begin
          cnt_d = DLY_W'(1);
          st_d = (rel_del <= DLY_W'(1)) ? ST_IDLE : ST_RELEASING;
        end
      end
      ST_RELEASING: begin
        if (uv) begin
          cnt_d = '0;
          st_d = ST_STARTED;
        end else begin
          cnt_d = cnt_q + DLY_W'(1);
          if (cnt_d >= rel_del) begin
            cnt_d = '0;
            st_d = ST_IDLE;
          end
        end
      end
      default: begin
        cnt_d = '0;
        st_d = ST_IDLE;
      end
    endcase
    if (!active) begin
      cnt_d = '0;
      st_d = ST_IDLE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_q <= ST_IDLE;
      cnt_q <= '0;
    end else if (i_meas_valid) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
    end
  end

  // ----------------------------------------
  // outputs with blocking and forcing
  // ----------------------------------------
  always_comb begin
    start_d = pickup && !blk && active;
    trip_d = start_d && ovc;
    blocked_d = pickup && blk && active;
    if (force_en_q && active) begin
      start_d = force_code_q == COND_START || force_code_q == COND_TRIP;
      trip_d = force_code_q == COND_TRIP;
      blocked_d = force_code_q == COND_BLOCKED;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      start_q <= 1'b0;
      trip_q <= 1'b0;
      blocked_q <= 1'b0;
      v_ratio_q <= '0;
      i_ratio_q <= '0;
    end else if (i_meas_valid) begin
      start_q <= start_d;
      trip_q <= trip_d;
      blocked_q <= blocked_d;
      v_ratio_q <= ratio({16'h0, i_meas.pos_seq_voltage} * 32'h64, {2'h0, ulim});
      i_ratio_q <= ratio({16'h0, min_i} * 32'h14, {10'h0, ilim});
    end
  end

  assign o_start = start_q;
  assign o_trip = trip_q;
  assign o_blocked = blocked_q;

  // ----------------------------------------
  // millisecond time stamp
  // ----------------------------------------
  assign ms_tick = div_q == 18'(MS_TICK - 1);

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      div_q <= '0;
      ts_q <= '0;
    end else if (ms_tick) begin
      div_q <= '0;
      ts_q <= ts_q + 32'h1;
    end else begin
      div_q <= div_q + 18'h1;
    end
  end

  // ----------------------------------------
  // events, one stamp shared by all changes
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_event <= '0;
    end else begin
      o_event.changed <= '0;
      if (i_meas_valid) begin
        o_event.changed <= {blocked_d != blocked_q, trip_d != trip_q, start_d != start_q};
        o_event.level <= {blocked_d, trip_d, start_d};
        o_event.stamp <= ts_q;
      end
    end
  end

  // ----------------------------------------
  // cumulative counters, count and clear in one cycle leave 1
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cnt_start_q <= '0;
      cnt_trip_q <= '0;
      cnt_blk_q <= '0;
    end else begin
      if (i_meas_valid && start_d && !start_q) begin
        cnt_start_q <= clr_d[0] ? 16'h1 : cnt_start_q + 16'h1;
      end else if (clr_d[0]) begin
        cnt_start_q <= '0;
      end
      if (i_meas_valid && trip_d && !trip_q) begin
        cnt_trip_q <= clr_d[1] ? 16'h1 : cnt_trip_q + 16'h1;
      end else if (clr_d[1]) begin
        cnt_trip_q <= '0;
      end
      if (i_meas_valid && blocked_d && !blocked_q) begin
        cnt_blk_q <= clr_d[2] ? 16'h1 : cnt_blk_q + 16'h1;
      end else if (clr_d[2]) begin
        cnt_blk_q <= '0;
      end
    end
  end

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  assign grp = i_addr[6:4];
  assign fld = i_addr[3:2];
  assign clr_d = (i_wr && i_addr == REG_CNT_CLR) ? i_wdata[2:0] : 3'h0;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      mode_q <= MODE_ON;
      force_en_q <= 1'b0;
      force_code_q <= COND_NORMAL;
      instant_q <= 1'b0;
    end else if (i_wr) begin
      if (i_addr == REG_MODE) begin
        if (i_wdata[2:0] >= MODE_ON && i_wdata[2:0] <= MODE_OFF) begin
          mode_q <= i_wdata[2:0];
        end
      end else if (i_addr == REG_FORCE) begin
        force_en_q <= i_wdata[FORCE_EN_BIT];
        force_code_q <= i_wdata[1:0];
      end else if (i_addr == REG_VARIANT) begin
        instant_q <= i_wdata[0];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      for (int g = 0; g < NUM_GROUPS; g++) begin
        ulim_q[g] <= ULIM_RST;
        act_q[g] <= ACT_RST;
        ilim_q[g] <= ILIM_RST;
        rel_q[g] <= REL_RST;
      end
    end else if (i_wr && i_addr >= REG_GROUP_BASE) begin
      if (fld == 2'h0) begin
        ulim_q[grp] <= i_wdata[13:0];
      end else if (fld == 2'h1) begin
        act_q[grp] <= i_wdata[DLY_W-1:0];
      end else if (fld == 2'h2) begin
        ilim_q[grp] <= i_wdata[5:0];
      end else begin
        rel_q[grp] <= i_wdata[DLY_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // register reads, one cycle latency
  // ----------------------------------------
  assign remain = (st_q == ST_ARMING) ? 20'({1'b0, act_del} - {1'b0, cnt_q}) : 20'h0;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      if (i_addr == REG_MODE) begin
        o_rdata <= {29'h0, mode_q};
      end else if (i_addr == REG_FORCE) begin
        o_rdata <= {27'h0, force_en_q, 2'h0, force_code_q};
      end else if (i_addr == REG_VARIANT) begin
        o_rdata <= {31'h0, instant_q};
      end else if (i_addr == REG_COND) begin
        o_rdata <= {30'h0, trip_q ? COND_TRIP : blocked_q ? COND_BLOCKED :
                    start_q ? COND_START : COND_NORMAL};
      end else if (i_addr == REG_BEHAV) begin
        o_rdata <= {29'h0, mode_q};
      end else if (i_addr == REG_EXP_TIME) begin
        o_rdata <= {13'h0, act_del};
      end else if (i_addr == REG_REMAIN) begin
        o_rdata <= {{12{remain[19]}}, remain};
      end else if (i_addr == REG_V_RATIO) begin
        o_rdata <= {15'h0, v_ratio_q};
      end else if (i_addr == REG_I_RATIO) begin
        o_rdata <= {15'h0, i_ratio_q};
      end else if (i_addr == REG_CNT_START) begin
        o_rdata <= {16'h0, cnt_start_q};
      end else if (i_addr == REG_CNT_TRIP) begin
        o_rdata <= {16'h0, cnt_trip_q};
      end else if (i_addr == REG_CNT_BLK) begin
        o_rdata <= {16'h0, cnt_blk_q};
      end else if (i_addr >= REG_GROUP_BASE) begin
        if (fld == 2'h0) begin
          o_rdata <= {18'h0, ulim_q[grp]};
        end else if (fld == 2'h1) begin
          o_rdata <= {13'h0, act_q[grp]};
        end else if (fld == 2'h2) begin
          o_rdata <= {26'h0, ilim_q[grp]};
        end else begin
          o_rdata <= {13'h0, rel_q[grp]};
        end
      end else begin
        o_rdata <= '0;
      end
    end else begin
      o_rdata <= '0;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  a_start_needs_unblock: assert property (i_meas_valid && blk && !force_en_q |=> !o_start)
    else $error("start output asserted while blocked");

  a_blocked_on_pickup: assert property (i_meas_valid && blk && !force_en_q && active &&
      (st_d == ST_STARTED || st_d == ST_RELEASING) |=> o_blocked && !o_trip)
    else $error("blocked pick-up did not raise blocked output");

  a_trip_all_phases: assert property (i_meas_valid && !force_en_q |=> o_trip == (o_start && $past(ovc)))
    else $error("trip does not follow start and phase currents");

  a_event_on_change: assert property (o_start != $past(o_start) |-> o_event.changed[0])
    else $error("start change without event");

  a_shared_stamp: assert property ($rose(o_start) && $rose(o_trip) |->
      o_event.changed[1:0] == 2'h3 && o_event.stamp == $past(ts_q))
    else $error("start and trip events not stamped together");

  a_stamp_tick: assert property (ms_tick |=> ts_q == $past(ts_q) + 32'h1)
    else $error("time stamp did not advance on tick");

  a_trip_counter: assert property ($rose(o_trip) && !$past(clr_d[1]) |->
      cnt_trip_q == $past(cnt_trip_q) + 16'h1)
    else $error("trip counter did not count");

  a_off_quiet: assert property (i_meas_valid && mode_q == MODE_OFF |=>
      !o_start && !o_trip && !o_blocked)
    else $error("outputs active in off mode");

  a_act_wait: assert property (i_meas_valid && st_q == ST_ARMING && uv &&
      cnt_q + DLY_W'(1) < act_del && active |=> st_q == ST_ARMING)
    else $error("start condition before activation delay");

  a_release_hold: assert property (i_meas_valid && st_q == ST_RELEASING && !uv &&
      cnt_q + DLY_W'(1) < rel_del && active |=> st_q == ST_RELEASING)
    else $error("start condition released early");

  a_hold_between: assert property (!i_meas_valid |=> st_q == $past(st_q) && o_trip == $past(o_trip))
    else $error("state moved without measurement update");

endmodule

`default_nettype wire

//--- sim/meas_source.sv
// measurement and blocking source model feeding the protection stage
`timescale 1ns/100ps
`default_nettype none

module meas_source #(
  parameter int unsigned PERIOD = 50
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [15:0] i_cur_a,
  input wire logic [15:0] i_cur_b,
  input wire logic [15:0] i_cur_c,
  input wire logic [15:0] i_volt,
  input wire logic i_blk_req,
  output logic o_meas_valid,
  output iae_pkg::meas_t o_meas,
  output logic o_block
);
  import iae_pkg::*;

  logic [15:0] cnt_q;
  logic due;

  assign due = !i_sys_rst && (cnt_q == 16'(PERIOD - 1));

  // ----------------------------------------
  // update time base
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || due) begin
      cnt_q <= 16'h0;
    end else begin
      cnt_q <= cnt_q + 16'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    o_meas_valid <= due;
  end

  // ----------------------------------------
  // fresh values on update, measurements scrambled between, block held
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_meas <= '0;
      o_block <= 1'b0;
    end else if (due) begin
      o_meas <= {i_cur_a, i_cur_b, i_cur_c, i_volt};
      o_block <= i_blk_req;
    end else begin
      o_meas <= ~o_meas;
    end
  end
endmodule

`default_nettype wire

//--- sim/tb_top.sv
// self-checking bench for the inadvertent energizing protection stage
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import iae_pkg::*;

  localparam int unsigned TICK = 10;
  logic i_clk, i_sys_rst, i_wr, i_rd, meas_valid, block, blk_req;
  logic o_start, o_trip, o_blocked;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, o_rdata, rd_val, stamp0;
  logic [2:0] i_group_sel;
  logic [15:0] cur_a, cur_b, cur_c, volt;
  logic [2:0] fexp [4] = '{3'b000, 3'b001, 3'b011, 3'b100};
  meas_t meas;
  event_t o_event, ev;
  int err_count, num_checks;

  meas_source #(.PERIOD(5 * TICK)) i_meas_source (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cur_a(cur_a), .i_cur_b(cur_b),
    .i_cur_c(cur_c), .i_volt(volt), .i_blk_req(blk_req),
    .o_meas_valid(meas_valid), .o_meas(meas), .o_block(block)
  );

  inadvertent_energizing_protection #(.MS_TICK(TICK)) i_inadvertent_energizing_protection (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_meas_valid(meas_valid), .i_meas(meas),
    .i_block(block), .i_group_sel(i_group_sel), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_start(o_start), .o_trip(o_trip),
    .o_blocked(o_blocked), .o_event(o_event)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    rd_val = o_rdata;
    chk(what, rd_val, exp);
  endtask

  // one measurement update, then outputs compared
  task automatic upd(input logic [15:0] v, a, b, c, input logic bk, input logic [2:0] so);
    int n;
    volt <= v;
    cur_a <= a;
    cur_b <= b;
    cur_c <= c;
    blk_req <= bk;
    n = 0;
    do begin
      @(posedge i_clk);
      #1;
      n++;
    end while (meas_valid !== 1'b1 && n < 200);
    @(posedge i_clk);
    #1;
    ev = o_event;
    chk("outputs", {29'h0, o_blocked, o_trip, o_start}, {29'h0, so});
  endtask

  task automatic results();
    if (err_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    err_count++;
    results();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    i_sys_rst = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h0;
    i_wdata = 32'h0;
    i_group_sel = 3'h3;
    volt = 16'h1770;
    cur_a = 16'h0;
    cur_b = 16'h0;
    cur_c = 16'h0;
    blk_req = 1'b0;
    err_count = 0;
    num_checks = 0;
    repeat (8) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rchk("mode", REG_MODE, 32'h1);
    rchk("force", REG_FORCE, 32'h0);
    rchk("behaviour", REG_BEHAV, 32'h1);
    rchk("condition", REG_COND, 32'h0);
    rchk("exp time", REG_EXP_TIME, 32'h3e8);
    rchk("ulim", 8'hf0, 32'h1388);
    rchk("act", 8'h84, 32'h3e8);
    rchk("ilim", 8'h88, 32'h1);
    rchk("rel", 8'hfc, 32'h32);
    rchk("unmapped", 8'h7c, 32'h0);
    wr(REG_MODE, 32'h6);
    rchk("bad mode", REG_MODE, 32'h1);
    for (int m = 5; m >= 1; m--) begin
      wr(REG_MODE, 32'(m));
      rchk("behaviour", REG_BEHAV, 32'(m));
    end
    // group 3 short delays, group 0 left at defaults
    wr(8'hb4, 32'h3);
    wr(8'hb8, 32'h2);
    wr(8'hbc, 32'h2);
    rchk("exp time g3", REG_EXP_TIME, 32'h3);
    @(posedge i_clk);
    i_group_sel <= 3'h0;
    rchk("exp time g0", REG_EXP_TIME, 32'h3e8);
    @(posedge i_clk);
    i_group_sel <= 3'h3;
    upd(16'h03e8, 16'h5, 16'h5, 16'h5, 1'b0, 3'b000);
    rchk("dummy", 8'h7c, 32'h0);
    rchk("remaining", REG_REMAIN, 32'h2);
    @(posedge i_clk);
    #1;
    chk("rdata idle", o_rdata, 32'h0);
    upd(16'h03e8, 16'h5, 16'h5, 16'h5, 1'b0, 3'b000);
    upd(16'h03e8, 16'h5, 16'h5, 16'h5, 1'b0, 3'b001);
    chk("start event", {26'h0, ev.changed, ev.level}, 32'h9);
    rchk("condition", REG_COND, 32'h1);
    rchk("v ratio", REG_V_RATIO, 32'h14);
    rchk("i ratio", REG_I_RATIO, 32'h32);
    upd(16'h03e8, 16'h14, 16'h14, 16'ha, 1'b0, 3'b001);
    upd(16'h1770, 16'h14, 16'h14, 16'h14, 1'b0, 3'b011);
    rchk("condition", REG_COND, 32'h2);
    upd(16'h1770, 16'h14, 16'h14, 16'h5, 1'b0, 3'b000);
    chk("release event", {26'h0, ev.changed, ev.level}, 32'h18);
    rchk("start count", REG_CNT_START, 32'h1);
    rchk("trip count", REG_CNT_TRIP, 32'h1);
    wr(REG_CNT_CLR, 32'h3);
    rchk("start count", REG_CNT_START, 32'h0);
    rchk("trip count", REG_CNT_TRIP, 32'h0);
    // instant variant
    wr(REG_VARIANT, 32'h1);
    rchk("exp time", REG_EXP_TIME, 32'h0);
    upd(16'h03e8, 16'h14, 16'h14, 16'h14, 1'b0, 3'b011);
    chk("instant event", {26'h0, ev.changed, ev.level}, 32'h1b);
    stamp0 = ev.stamp;
    upd(16'h1770, 16'h5, 16'h5, 16'h5, 1'b0, 3'b001);
    chk("trip off event", {26'h0, ev.changed, ev.level}, 32'h11);
    chk("stamp step", ev.stamp - stamp0, 32'h5);
    upd(16'h1770, 16'h5, 16'h5, 16'h5, 1'b0, 3'b000);
    // blocked pick-up, then off
    upd(16'h03e8, 16'h14, 16'h14, 16'h14, 1'b1, 3'b100);
    rchk("condition", REG_COND, 32'h3);
    rchk("blocked count", REG_CNT_BLK, 32'h1);
    wr(REG_CNT_CLR, 32'h4);
    rchk("blocked count", REG_CNT_BLK, 32'h0);
    wr(REG_MODE, 32'h5);
    upd(16'h03e8, 16'h14, 16'h14, 16'h14, 1'b0, 3'b000);
    wr(REG_MODE, 32'h2);
    upd(16'h03e8, 16'h14, 16'h14, 16'h14, 1'b0, 3'b100);
    // forcing codes
    wr(REG_MODE, 32'h1);
    for (int f = 1; f <= 3; f++) begin
      wr(REG_FORCE, 32'h10 | 32'(f));
      upd(16'h1770, 16'h5, 16'h5, 16'h5, 1'b0, fexp[f]);
    end
    wr(REG_FORCE, 32'h0);
    upd(16'h1770, 16'h5, 16'h5, 16'h5, 1'b0, 3'b000);
    results();
  end
endmodule

`default_nettype wire
